// *** logic/tsc_system_config.sv ***
// System configuration and command register with the transceive command sequencer.
// Assumes an Avalon-MM master on the same clock and a datapath on the same clock
// that reports end of transmission and end of reception as one-cycle pulses.
//
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none

// What this block does
// - Bit 9 is read-write, picks card-emulation entry state, resets to zero.
// - Writing one to write-only bit 8 resets the whole device.
// - Bit 6 set routes transmit and receive data through the card cipher.
// - Bit 5 picks pattern length: one gives 15 stages, zero gives 9.
// - Setting bit 3 triggers a transmission as the sequencer orders it.
// - Low three bits hold the command and reset to code 001.
// - Code 000 aborts all communication and returns to idle.
// - Code 011 starts a transceive cycle.
// - Transceive entry transmits if initiator, otherwise enables the receiver first.
// - The transceive cycle never ends by itself, only by writing code 000, 101 or 110, or by a soft reset.
// - Code 100 keeps the stored command while other written bits apply.
// - Code 101 loopback starts transmission and enables the receiver together.
// - Code 110 sends pseudo-random data endlessly at the selected length.
module tsc_system_config
    import tsc_pkg::*;
#(
    parameter int unsigned RESET_PULSE_CYCLES = SOFT_RESET_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        initiator,
    input  wire logic        tx_done,
    input  wire logic        rx_done,
    output logic             tx_start,
    output logic             tx_active,
    output logic             rx_enable,
    output logic             cipher_enable,
    output logic             pseudo_random_pattern_length_select,
    output logic             emulation_entry_state_select,
    output logic             prbs_bit,
    output logic             prbs_valid,
    output logic             device_reset
);
    tsc_main_t   st_r;
    tsc_main_t   st_nxt;
    logic        wr_take;
    logic        soft_req;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [31:0] wmask;
    logic [31:0] wmerge;
    logic [2:0]  wcmd;

    // Register image of the configuration, bit 8 and bits above 9 read zero
    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[BIT_CMD_HI:BIT_CMD_LO] = st_r.cfg.command;
        cfg_word[BIT_START_SEND]        = st_r.cfg.start_send;
        cfg_word[BIT_RSV4]              = st_r.cfg.rsv4;
        cfg_word[BIT_PRBS_LEN]          = st_r.cfg.prbs_len;
        cfg_word[BIT_CIPHER]            = st_r.cfg.cipher;
        cfg_word[BIT_RSV7]              = st_r.cfg.rsv7;
        cfg_word[BIT_EMUL_ENTRY]        = st_r.cfg.emul_entry;
        stat_word = 32'h0000_0000;
        stat_word[BIT_ST_MODE_HI:BIT_ST_MODE_LO] = st_r.mode;
        stat_word[BIT_ST_TX_BUSY]                = st_r.tx_busy;
        stat_word[BIT_ST_RX_EN]                  = rx_enable;
    end

    // Byte-lane merge of a write into the current configuration image
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{byteenable[i]}};
        end
        wmerge = (cfg_word & ~wmask) | (writedata & wmask);
        wcmd   = wmerge[BIT_CMD_HI:BIT_CMD_LO];
    end

    // A request is taken on the second cycle, when waitrequest is low
    assign waitrequest = (read | write) & ~st_r.ack;
    assign wr_take     = write & st_r.ack & (address == OFS_SYSCFG);
    assign soft_req    = wr_take & wmerge[BIT_SOFT_RESET];

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ack      = (read | write) & ~st_r.ack;
        st_nxt.tx_start = 1'b0;
        if (read & ~st_r.ack) begin
            if (address == OFS_SYSCFG) begin
                st_nxt.rdata = cfg_word;
            end else if (address == OFS_STATUS) begin
                st_nxt.rdata = stat_word;
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end

        // Sequencer progress inside the current command
        case (st_r.mode)
            MODE_TX: begin
                if (!st_r.tx_busy && st_r.cfg.start_send) begin
                    st_nxt.tx_busy        = 1'b1;
                    st_nxt.tx_start       = 1'b1;
                    st_nxt.cfg.start_send = 1'b0;
                end else if (st_r.tx_busy && tx_done) begin
                    st_nxt.tx_busy = 1'b0;
                    st_nxt.mode    = MODE_RX;
                end
            end
            MODE_RX: begin
                if (rx_done) begin
                    st_nxt.mode = MODE_TX;
                end
            end
            MODE_LOOP: begin
                if (tx_done) begin
                    st_nxt.tx_busy = 1'b0;
                end
            end
            default: begin
            end
        endcase

        // Software write, applied after progress so a written one wins
        if (soft_req) begin
            st_nxt = MAIN_RESET;
        end else if (wr_take) begin
            st_nxt.cfg.emul_entry = wmerge[BIT_EMUL_ENTRY];
            st_nxt.cfg.rsv7       = wmerge[BIT_RSV7];
            st_nxt.cfg.cipher     = wmerge[BIT_CIPHER];
            st_nxt.cfg.prbs_len   = wmerge[BIT_PRBS_LEN];
            st_nxt.cfg.rsv4       = wmerge[BIT_RSV4];
            if (wmerge[BIT_START_SEND]) begin
                st_nxt.cfg.start_send = 1'b1;
            end else begin
                st_nxt.cfg.start_send = 1'b0;
            end
            if (wcmd != CMD_KEEP) begin
                st_nxt.cfg.command = wcmd;
            end
            case (wcmd)
                CMD_IDLE: begin
                    st_nxt.mode    = MODE_IDLE;
                    st_nxt.tx_busy = 1'b0;
                end
                CMD_TRANSCEIVE: begin
                    if (initiator) begin
                        st_nxt.mode     = MODE_TX;
                        st_nxt.tx_busy  = 1'b1;
                        st_nxt.tx_start = 1'b1;
                    end else begin
                        st_nxt.mode    = MODE_RX;
                        st_nxt.tx_busy = 1'b0;
                    end
                end
                CMD_LOOPBACK: begin
                    st_nxt.mode     = MODE_LOOP;
                    st_nxt.tx_busy  = 1'b1;
                    st_nxt.tx_start = 1'b1;
                end
                CMD_PRBS: begin
                    st_nxt.mode    = MODE_PRBS;
                    st_nxt.tx_busy = 1'b1;
                end
                default: begin
                    // Keep and the reserved codes leave the sequencer as it is
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r <= MAIN_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    tsc_reset_pulse #(
        .CYCLES (RESET_PULSE_CYCLES)
    ) u_reset_pulse (
        .clock   (clock),
        .reset_n (reset_n),
        .trigger (soft_req),
        .pulse   (device_reset)
    );

    tsc_prbs_gen u_prbs (
        .clock    (clock),
        .reset_n  (reset_n),
        .enable   (st_r.mode == MODE_PRBS),
        .long_seq (st_r.cfg.prbs_len),
        .bit_out  (prbs_bit),
        .valid    (prbs_valid)
    );

    assign readdata                            = st_r.rdata;
    assign tx_start                            = st_r.tx_start;
    assign tx_active                           = st_r.tx_busy;
    assign rx_enable                           = (st_r.mode == MODE_RX) |
                                                 (st_r.mode == MODE_LOOP);
    assign cipher_enable                       = st_r.cfg.cipher;
    assign pseudo_random_pattern_length_select = st_r.cfg.prbs_len;
    assign emulation_entry_state_select        = st_r.cfg.emul_entry;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_entry_state;
        wr_take && !soft_req |=>
            emulation_entry_state_select == $past(wmerge[BIT_EMUL_ENTRY]);
    endproperty
    a_entry_state: assert property (p_entry_state)
        else $error("entry state select did not follow the write");

    property p_soft_reset;
        soft_req |=> device_reset && st_r.mode == MODE_IDLE
                     && st_r.cfg.command == CMD_RESET_VAL;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset write did not reset the device");

    property p_cipher;
        wr_take && !soft_req |=> cipher_enable == $past(wmerge[BIT_CIPHER]);
    endproperty
    a_cipher: assert property (p_cipher)
        else $error("cipher enable did not follow the write");

    property p_prbs_len;
        st_r.mode == MODE_PRBS && !wr_take |=>
            pseudo_random_pattern_length_select == $past(st_r.cfg.prbs_len);
    endproperty
    a_prbs_len: assert property (p_prbs_len)
        else $error("pattern length changed without a write");

    property p_start_send;
        st_r.mode == MODE_TX && !st_r.tx_busy && st_r.cfg.start_send && !wr_take
            |=> tx_start && tx_active ##1 !tx_start;
    endproperty
    a_start_send: assert property (p_start_send)
        else $error("start send did not launch one transmission");

    property p_cmd_reset;
        $rose(reset_n) |-> st_r.cfg.command == CMD_RESET_VAL && st_r.mode == MODE_IDLE;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset)
        else $error("command field not at its reset code");

    property p_idle;
        wr_take && !soft_req && wcmd == CMD_IDLE |=>
            st_r.mode == MODE_IDLE && !tx_active && !rx_enable;
    endproperty
    a_idle: assert property (p_idle)
        else $error("stop command did not return to idle");

    property p_transceive;
        wr_take && !soft_req && wcmd == CMD_TRANSCEIVE |=>
            st_r.mode == ($past(initiator) ? MODE_TX : MODE_RX)
            && tx_start == $past(initiator);
    endproperty
    a_transceive: assert property (p_transceive)
        else $error("transceive entry went to the wrong phase");

    property p_no_self_end;
        (st_r.mode == MODE_TX || st_r.mode == MODE_RX)
            && !(wr_take && wcmd == CMD_IDLE) && !soft_req
            |=> st_r.mode != MODE_IDLE;
    endproperty
    a_no_self_end: assert property (p_no_self_end)
        else $error("transceive cycle ended without a stop command");

    property p_keep;
        wr_take && !soft_req && wcmd == CMD_KEEP |=>
            st_r.cfg.command == $past(st_r.cfg.command) && $stable(st_r.mode);
    endproperty
    a_keep: assert property (p_keep)
        else $error("keep code changed the stored command");

    property p_loopback;
        wr_take && !soft_req && wcmd == CMD_LOOPBACK |=>
            tx_start && tx_active && rx_enable;
    endproperty
    a_loopback: assert property (p_loopback)
        else $error("loopback did not start tx and rx together");

    property p_prbs;
        wr_take && !soft_req && wcmd == CMD_PRBS |=>
            st_r.mode == MODE_PRBS ##1 prbs_valid [*3];
    endproperty
    a_prbs: assert property (p_prbs)
        else $error("pattern command did not stream data");

    property p_entry_hold;
        !wr_take |=> $stable(emulation_entry_state_select);
    endproperty
    a_entry_hold: assert property (p_entry_hold)
        else $error("entry state select changed without a write");

    property p_cipher_hold;
        !wr_take |=> $stable(cipher_enable);
    endproperty
    a_cipher_hold: assert property (p_cipher_hold)
        else $error("cipher enable changed without a write");

    property p_idle_quiet;
        st_r.mode == MODE_IDLE |-> !tx_active && !rx_enable;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("idle mode with transmitter or receiver on");

    property p_rx_phase;
        st_r.mode == MODE_RX |-> rx_enable && !tx_active;
    endproperty
    a_rx_phase: assert property (p_rx_phase)
        else $error("receive phase with transmitter busy");

    property p_prbs_endless;
        st_r.mode == MODE_PRBS && $past(st_r.mode) == MODE_PRBS |->
            prbs_valid && tx_active;
    endproperty
    a_prbs_endless: assert property (p_prbs_endless)
        else $error("pattern stream stopped in pattern mode");

    property p_never_keep;
        st_r.cfg.command != CMD_KEEP;
    endproperty
    a_never_keep: assert property (p_never_keep)
        else $error("keep code was stored as a command");

    c_transceive_tx: cover property (wr_take && wcmd == CMD_TRANSCEIVE && initiator);
    c_tx_to_rx: cover property (st_r.mode == MODE_TX ##1 st_r.mode == MODE_RX);
    c_loopback: cover property (st_r.mode == MODE_LOOP && tx_active);
    c_prbs_long: cover property (prbs_valid && pseudo_random_pattern_length_select);
    c_soft_reset: cover property (soft_req);

endmodule : tsc_system_config

`default_nettype wire

// *** logic/tsc_pkg.sv ***
// Constants, field layout and carrier types of the system configuration block.
// Assumes a single 100 MHz clock domain shared by all users of the package.
`default_nettype none

package tsc_pkg;

    // Register byte addresses on the Avalon-MM slave
    localparam logic [3:0]  OFS_SYSCFG = 4'h0;
    localparam logic [3:0]  OFS_STATUS = 4'h4;

    // system_configuration field positions
    localparam int unsigned BIT_CMD_LO     = 0;
    localparam int unsigned BIT_CMD_HI     = 2;
    localparam int unsigned BIT_START_SEND = 3;
    localparam int unsigned BIT_RSV4       = 4;
    localparam int unsigned BIT_PRBS_LEN   = 5;
    localparam int unsigned BIT_CIPHER     = 6;
    localparam int unsigned BIT_RSV7       = 7;
    localparam int unsigned BIT_SOFT_RESET = 8;
    localparam int unsigned BIT_EMUL_ENTRY = 9;

    // Status register field positions
    localparam int unsigned BIT_ST_MODE_LO = 0;
    localparam int unsigned BIT_ST_MODE_HI = 4;
    localparam int unsigned BIT_ST_TX_BUSY = 5;
    localparam int unsigned BIT_ST_RX_EN   = 6;

    // Command codes
    localparam logic [2:0]  CMD_IDLE       = 3'h0;
    localparam logic [2:0]  CMD_RESET_VAL  = 3'h1;
    localparam logic [2:0]  CMD_TRANSCEIVE = 3'h3;
    localparam logic [2:0]  CMD_KEEP       = 3'h4;
    localparam logic [2:0]  CMD_LOOPBACK   = 3'h5;
    localparam logic [2:0]  CMD_PRBS       = 3'h6;

    // Soft reset pulse length towards the rest of the device, in cycles
    localparam int unsigned SOFT_RESET_CYCLES = 4;

    // Pseudo-random generator: register width, taps and seed
    localparam int unsigned LFSR_W      = 15;
    localparam int unsigned PRBS9_TAP_A = 8;
    localparam int unsigned PRBS9_TAP_B = 4;
    localparam int unsigned PRBS15_TAP_A = 14;
    localparam int unsigned PRBS15_TAP_B = 13;
    localparam logic [14:0] LFSR_SEED   = 15'h7fff;

    typedef enum logic [4:0] {
        MODE_IDLE = 5'b00001,
        MODE_TX   = 5'b00010,
        MODE_RX   = 5'b00100,
        MODE_LOOP = 5'b01000,
        MODE_PRBS = 5'b10000
    } tsc_mode_t;

    typedef struct packed {
        logic       emul_entry;
        logic       rsv7;
        logic       cipher;
        logic       prbs_len;
        logic       rsv4;
        logic       start_send;
        logic [2:0] command;
    } tsc_cfg_t;

    localparam tsc_cfg_t CFG_RESET = '{
        emul_entry: 1'b0, rsv7: 1'b0, cipher: 1'b0, prbs_len: 1'b0,
        rsv4: 1'b0, start_send: 1'b0, command: CMD_RESET_VAL};

    typedef struct packed {
        tsc_cfg_t    cfg;
        tsc_mode_t   mode;
        logic        ack;
        logic [31:0] rdata;
        logic        tx_busy;
        logic        tx_start;
    } tsc_main_t;

    localparam tsc_main_t MAIN_RESET = '{
        cfg: CFG_RESET, mode: MODE_IDLE, ack: 1'b0,
        rdata: 32'h0000_0000, tx_busy: 1'b0, tx_start: 1'b0};

endpackage : tsc_pkg

`default_nettype wire

// *** logic/tsc_reset_pulse.sv ***
// Stretches a one-cycle soft reset request into a fixed-length pulse.
// Assumes the trigger comes from logic on the same clock.
`default_nettype none

module tsc_reset_pulse
    import tsc_pkg::*;
#(
    parameter int unsigned CYCLES = SOFT_RESET_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic trigger,
    output logic      pulse
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          active;
    } tsc_rp_t;

    tsc_rp_t st_r;
    tsc_rp_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (trigger) begin
            st_nxt.cnt    = CW'(CYCLES - 1);
            st_nxt.active = 1'b1;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
        end else begin
            st_nxt.active = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse = st_r.active;

endmodule : tsc_reset_pulse

`default_nettype wire

// *** logic/tsc_prbs_gen.sv ***
// Pseudo-random pattern source, 9-stage or 15-stage sequence, one bit a cycle.
// Assumes enable and length select come from logic on the same clock.
`default_nettype none

module tsc_prbs_gen
    import tsc_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic long_seq,
    output logic      bit_out,
    output logic      valid
);
    typedef struct packed {
        logic [LFSR_W-1:0] lfsr;
        logic              bit_q;
        logic              valid;
    } tsc_prbs_t;

    tsc_prbs_t st_r;
    tsc_prbs_t st_nxt;
    logic      fb;

    always_comb begin
        st_nxt = st_r;
        fb = long_seq ? (st_r.lfsr[PRBS15_TAP_A] ^ st_r.lfsr[PRBS15_TAP_B])
                      : (st_r.lfsr[PRBS9_TAP_A] ^ st_r.lfsr[PRBS9_TAP_B]);
        if (enable) begin
            st_nxt.lfsr  = {st_r.lfsr[LFSR_W-2:0], fb};
            st_nxt.bit_q = fb;
            st_nxt.valid = 1'b1;
        end else begin
            // Restart from the seed so every run emits the same sequence
            st_nxt.lfsr  = LFSR_SEED;
            st_nxt.bit_q = 1'b0;
            st_nxt.valid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r <= '{lfsr: LFSR_SEED, bit_q: 1'b0, valid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bit_out = st_r.bit_q;
    assign valid   = st_r.valid;

endmodule : tsc_prbs_gen

`default_nettype wire

// *** verification/tsc_datapath_model.sv ***
// Datapath model: ends each transmission and reception after DLY cycles.
// Assumes the sequencer outputs of the configuration block on the same clock.
`default_nettype none

module tsc_datapath_model #(
    parameter int unsigned DLY = 3
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic respond,
    input  wire logic tx_active,
    input  wire logic rx_enable,
    output logic      tx_done,
    output logic      rx_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] tcnt_r;
    logic [3:0] rcnt_r;

    // Silent while respond is low, so loopback and pattern runs never end
    always_ff @(posedge clock) begin
        if (!reset_n || !respond) begin
            tcnt_r  <= 4'h0;
            rcnt_r  <= 4'h0;
            tx_done <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            tcnt_r  <= (tx_active && !tx_done) ? tcnt_r + 4'h1 : 4'h0;
            rcnt_r  <= (rx_enable && !rx_done) ? rcnt_r + 4'h1 : 4'h0;
            tx_done <= tx_active && !tx_done && (tcnt_r == 4'(DLY - 1));
            rx_done <= rx_enable && !rx_done && (rcnt_r == 4'(DLY - 1));
        end
    end
endmodule : tsc_datapath_model

`default_nettype wire

// *** verification/tsc_system_config_test.sv ***
// Self-checking bench for the system configuration block.
// Assumes the datapath model answers while respond is high.
`default_nettype none

module tsc_system_config_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tsc_pkg::*;

    localparam int unsigned RPC = 4;

    logic        clock, reset_n, read, write, initiator, respond;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, rdat;
    logic        waitrequest, tx_done, rx_done, tx_start, tx_active, rx_enable;
    logic        cipher_enable, plen, emul, prbs_bit, prbs_valid, device_reset;
    logic [4:0]  outs;
    int          err_count, checks_done;

    assign outs = {tx_start, tx_active, rx_enable, prbs_valid, device_reset};

    tsc_system_config #(.RESET_PULSE_CYCLES(RPC)) tsc_system_config_inst (
        .clock(clock), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .initiator(initiator),
        .tx_done(tx_done), .rx_done(rx_done), .tx_start(tx_start),
        .tx_active(tx_active), .rx_enable(rx_enable), .cipher_enable(cipher_enable),
        .pseudo_random_pattern_length_select(plen),
        .emulation_entry_state_select(emul), .prbs_bit(prbs_bit),
        .prbs_valid(prbs_valid), .device_reset(device_reset));

    tsc_datapath_model #(.DLY(3)) tsc_datapath_model_inst (
        .clock(clock), .reset_n(reset_n), .respond(respond), .tx_active(tx_active),
        .rx_enable(rx_enable), .tx_done(tx_done), .rx_done(rx_done));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Holds the request until waitrequest is sampled low; only legal codes
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address   <= a;
        write     <= wr;
        read      <= !wr;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) cmp("bus_answer", 0, 1);
        rdat = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task wait_outs(input logic [4:0] m, input logic [4:0] e);
        int n;
        n = 0;
        while (((outs & m) !== (e & m)) && n < 10) begin
            @(posedge clock);
            n++;
        end
        cmp("outs", 32'(e & m), 32'(outs & m));
    endtask : wait_outs

    task t_reset;
        bus(1'b0, OFS_SYSCFG, 0);
        cmp("syscfg", 32'h0000_0001, rdat);
        cmp("emul", 0, emul);
        cmp("outs", 0, outs);
        bus(1'b0, 4'h8, 0);
        cmp("unmapped", 0, rdat);
        $display("reset test done");
    endtask : t_reset

    task t_fields;
        bus(1'b1, OFS_SYSCFG, 32'h0000_0260);
        @(posedge clock);
        cmp("fields", 3'b111, {emul, cipher_enable, plen});
        bus(1'b0, OFS_SYSCFG, 0);
        cmp("syscfg", 32'h0000_0260, rdat);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0000);
        $display("field test done");
    endtask : t_fields

    task t_xcv_init;
        respond   <= 1'b1;
        initiator <= 1'b1;
        bus(1'b1, OFS_SYSCFG, 32'h0000_0003);
        wait_outs(5'h1f, 5'b11000);
        wait_outs(5'h1f, 5'b00100);
        wait_outs(5'h1f, 5'b00000);
        repeat (20) @(posedge clock);
        cmp("outs", 0, outs);
        bus(1'b0, OFS_STATUS, 0);
        cmp("status", 32'h0000_0002, rdat & 32'h7f);
        bus(1'b1, OFS_SYSCFG, 32'h0000_004c);
        wait_outs(5'b10000, 5'b10000);
        bus(1'b0, OFS_SYSCFG, 0);
        cmp("syscfg", 32'h0000_0043, rdat & 32'h4f);
        cmp("cipher", 1, cipher_enable);
        wait_outs(5'h1f, 5'b00100);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0000);
        wait_outs(5'h1f, 5'b00000);
        bus(1'b0, OFS_STATUS, 0);
        cmp("status", 32'h0000_0001, rdat & 32'h7f);
        respond <= 1'b0;
        $display("transceive initiator test done");
    endtask : t_xcv_init

    task t_xcv_target;
        initiator <= 1'b0;
        bus(1'b1, OFS_SYSCFG, 32'h0000_0003);
        wait_outs(5'h1f, 5'b00100);
        repeat (8) @(posedge clock);
        cmp("outs", 5'b00100, outs);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0000);
        wait_outs(5'h1f, 5'b00000);
        $display("transceive target test done");
    endtask : t_xcv_target

    task t_loop;
        bus(1'b1, OFS_SYSCFG, 32'h0000_0005);
        wait_outs(5'b01111, 5'b01100);
        bus(1'b0, OFS_STATUS, 0);
        cmp("status", 32'h0000_0008, rdat & 32'h1f);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0000);
        wait_outs(5'h1f, 5'b00000);
        $display("loopback test done");
    endtask : t_loop

    // Short sequence repeats every 511 bits, the long one does not
    task t_prbs(input logic len);
        logic b [0:699];
        int   bad, diff;
        bad  = 0;
        diff = 0;
        bus(1'b1, OFS_SYSCFG, {26'h0, len, 5'h06});
        wait_outs(5'b00010, 5'b00010);
        cmp("plen", len, plen);
        for (int i = 0; i < 700; i++) begin
            @(posedge clock);
            b[i] = prbs_bit;
            if (prbs_valid !== 1'b1) bad++;
        end
        for (int i = 0; i < 189; i++) if (b[i] !== b[i + 511]) diff++;
        cmp("prbs_gaps", 0, bad);
        cmp("prbs_period", len, diff != 0);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0000);
        wait_outs(5'b00010, 5'b00000);
        $display("pattern test done");
    endtask : t_prbs

    task t_sreset;
        int n, w;
        n = 0;
        w = 0;
        bus(1'b1, OFS_SYSCFG, 32'h0000_0260);
        bus(1'b1, OFS_SYSCFG, 32'h0000_0100);
        while (device_reset !== 1'b1 && w < 10) begin
            @(posedge clock);
            w++;
        end
        while (device_reset === 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        cmp("reset_len", RPC, n);
        bus(1'b0, OFS_SYSCFG, 0);
        cmp("syscfg", 32'h0000_0001, rdat);
        cmp("cipher", 0, cipher_enable);
        $display("soft reset test done");
    endtask : t_sreset

    task stop_test;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    initial begin
        #300000;
        err_count++;
        stop_test;
    end

    initial begin
        {reset_n, read, write, initiator, respond} = 5'b0;
        address    = 4'h0;
        writedata  = 32'h0000_0000;
        byteenable = 4'hf;
        err_count  = 0;
        checks_done = 0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
        t_fields;
        t_xcv_init;
        t_xcv_target;
        t_loop;
        t_prbs(1'b0);
        t_prbs(1'b1);
        t_sreset;
        stop_test;
    end
endmodule : tsc_system_config_test

`default_nettype wire
